// [hdl/pielat_latch.sv]
// Interrupt event latch of the transceiver register set, with its
// rise/fall enables and live source status.
// Assumes the ULPI register engine gives one-cycle read and write
// strobes in the clk domain and that all inputs are synchronous.
`timescale 1ns/10ps
`default_nettype none
`include "pielat_regs.svh"

// Operation
// - Latch bit sets when its source changes in an enabled direction.
// - Bits: 4 id ground, 3 session end, 2 session valid, 1 vbus, 0 hostdisc.
// - Reading the latch register clears every latch bit.
// - Entering low power mode clears the latch register.
// - Entering serial or carkit mode clears it, regardless of clock suspend.
// - Host-disconnect bit has meaning only in host mode.
// - Host-disconnect bit after reset shows 1 when host disconnected.
// - Session-valid bit follows the shared A-valid signal.
// - Fall enables reset to 1; set/clear aliases act on written ones.
// - Status register shows live sources in latch bit positions.
// - Id ground frozen while pull-up off and 50 ms after enabling.
module pielat_latch #(
  parameter logic [`PIELAT_ID_CNT_W-1:0] ID_SETTLE_CYCLES =
    `PIELAT_ID_CNT_W'(`PIELAT_ID_SETTLE_MS * `PIELAT_CLK_KHZ)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic srcIdGround,
  input wire logic srcSessionEnd,
  input wire logic srcSessionValid,
  input wire logic srcBusPowerValid,
  input wire logic srcHostDisconnect,
  input wire logic hostMode,
  input wire logic idPullupControl,
  input wire logic lowPowerEnter,
  input wire logic serialModeEnter,
  input wire logic carkitModeEnter,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire pielat_pkg::pielat_addr_t regAddr,
  input wire pielat_pkg::pielat_byte_t regWrData,
  output pielat_pkg::pielat_byte_t regRdData,
  output logic regRdValid,
  output pielat_pkg::pielat_src_t eventLatch
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  pielat_pkg::pielat_src_t riseEn_r;
  pielat_pkg::pielat_src_t fallEn_r;
  pielat_pkg::pielat_src_t live_r;
  pielat_pkg::pielat_src_t live_nxt;
  pielat_pkg::pielat_src_t latch_r;
  pielat_pkg::pielat_src_t riseEvents;
  pielat_pkg::pielat_src_t fallEvents;
  pielat_pkg::pielat_src_t events;
  pielat_pkg::pielat_byte_t rdData_r;
  logic rdValid_r;
  logic pullupPrev_r;
  logic [`PIELAT_ID_CNT_W-1:0] idSettle_r;
  logic idUpdate;
  logic latchRead;
  logic latchClear;

  function automatic pielat_pkg::pielat_src_t apply_write(
    input pielat_pkg::pielat_src_t cur,
    input pielat_pkg::pielat_addr_t addr,
    input pielat_pkg::pielat_addr_t base,
    input pielat_pkg::pielat_src_t data
  );
    pielat_pkg::pielat_src_t res;
    res = cur;
    if (addr == base) begin
      res = data;
    end else if (addr == base + `PIELAT_ADDR_W'(1)) begin
      res = cur | data;
    end else if (addr == base + `PIELAT_ADDR_W'(2)) begin
      res = cur & ~data;
    end
    return res;
  endfunction : apply_write

  // Reserved bits 7 to 5 are never stored, so they read as zero
  function automatic pielat_pkg::pielat_byte_t to_byte(
    input pielat_pkg::pielat_src_t val
  );
    return {3'h0, val};
  endfunction : to_byte

  // ------------------------------------------------------------
  // Id ground settle window
  // ------------------------------------------------------------
  // Comparator may see a floating id pin until the pull-up settles
  always_ff @(posedge clk) begin
    if (rst) begin
      pullupPrev_r <= 1'b0;
    end else begin
      pullupPrev_r <= idPullupControl;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      idSettle_r <= '0;
    end else begin
      if (!idPullupControl) begin
        idSettle_r <= '0;
      end else if (!pullupPrev_r) begin
        idSettle_r <= ID_SETTLE_CYCLES;
      end else if (idSettle_r != '0) begin
        idSettle_r <= idSettle_r - `PIELAT_ID_CNT_W'(1);
      end
    end
  end

  assign idUpdate = idPullupControl && pullupPrev_r && idSettle_r == '0;

  // ------------------------------------------------------------
  // Source sampling and edge events
  // ------------------------------------------------------------
  always_comb begin
    live_nxt = live_r;
    if (idUpdate) begin
      live_nxt[`PIELAT_BIT_ID_GROUND] = srcIdGround;
    end
    live_nxt[`PIELAT_BIT_SESSION_END] = srcSessionEnd;
    live_nxt[`PIELAT_BIT_SESSION_VALID] = srcSessionValid;
    live_nxt[`PIELAT_BIT_BUS_POWER_VALID] = srcBusPowerValid;
    // Undefined outside host mode, so held at zero there
    live_nxt[`PIELAT_BIT_HOST_DISCONNECT] = srcHostDisconnect & hostMode;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      live_r <= `PIELAT_RST_STATUS;
    end else begin
      live_r <= live_nxt;
    end
  end

  // Host disconnect rises from reset zero if disconnected, so bit 0
  // reads 1 after reset with the default rise enable
  assign riseEvents = live_nxt & ~live_r & riseEn_r;
  assign fallEvents = ~live_nxt & live_r & fallEn_r;
  assign events = riseEvents | fallEvents;

  // ------------------------------------------------------------
  // Enable registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      riseEn_r <= `PIELAT_RST_RISE;
      fallEn_r <= `PIELAT_RST_FALL;
    end else if (regWrStb) begin
      riseEn_r <= apply_write(riseEn_r, regAddr, `PIELAT_OFS_RISE,
        regWrData[`PIELAT_SRC_W-1:0]);
      fallEn_r <= apply_write(fallEn_r, regAddr, `PIELAT_OFS_FALL,
        regWrData[`PIELAT_SRC_W-1:0]);
    end
  end

  // ------------------------------------------------------------
  // Latch
  // ------------------------------------------------------------
  assign latchRead = regRdStb && regAddr == `PIELAT_OFS_LATCH;
  assign latchClear = lowPowerEnter || serialModeEnter || carkitModeEnter;

  // Writes never reach this register
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_r <= `PIELAT_RST_LATCH;
    end else if (latchRead) begin
      latch_r <= '0;
    end else if (latchClear) begin
      // Mode clears are hardware events; a new edge still survives
      latch_r <= events;
    end else begin
      latch_r <= latch_r | events;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Valid follows every read strobe, mapped or not
  always_ff @(posedge clk) begin
    if (rst) begin
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= regRdStb;
    end
  end

  // Data holds between reads so a slow link may fetch it late
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_r <= 8'h00;
    end else if (regRdStb) begin
      unique case (regAddr)
        `PIELAT_OFS_RISE, `PIELAT_OFS_RISE_SET,
        `PIELAT_OFS_RISE_CLR: rdData_r <= to_byte(riseEn_r);
        `PIELAT_OFS_FALL, `PIELAT_OFS_FALL_SET,
        `PIELAT_OFS_FALL_CLR: rdData_r <= to_byte(fallEn_r);
        `PIELAT_OFS_STATUS: rdData_r <= to_byte(live_r);
        `PIELAT_OFS_LATCH: rdData_r <= to_byte(latch_r | events);
        default: rdData_r <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign regRdData = rdData_r;
  assign regRdValid = rdValid_r;
  assign eventLatch = latch_r;

endmodule : pielat_latch
`default_nettype wire

// [hdl/pielat_pkg.sv]
// Types shared by the interrupt event latch.
// Assumes pielat_regs.svh is on the include path.
`include "pielat_regs.svh"

package pielat_pkg;
  typedef logic [`PIELAT_SRC_W-1:0] pielat_src_t;
  typedef logic [`PIELAT_ADDR_W-1:0] pielat_addr_t;
  typedef logic [7:0] pielat_byte_t;
endpackage : pielat_pkg

// [hdl/pielat_regs.svh]
// Register offsets, field positions, reset values and timing counts
// for the interrupt event latch. Definitions only; included by name.
`ifndef PIELAT_REGS_SVH
`define PIELAT_REGS_SVH

// ------------------------------------------------------------
// Register offsets (6-bit register address space)
// ------------------------------------------------------------
`define PIELAT_ADDR_W 6
`define PIELAT_OFS_RISE 6'h0d
`define PIELAT_OFS_RISE_SET 6'h0e
`define PIELAT_OFS_RISE_CLR 6'h0f
`define PIELAT_OFS_FALL 6'h10
`define PIELAT_OFS_FALL_SET 6'h11
`define PIELAT_OFS_FALL_CLR 6'h12
`define PIELAT_OFS_STATUS 6'h13
`define PIELAT_OFS_LATCH 6'h14

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PIELAT_SRC_W 5
`define PIELAT_BIT_ID_GROUND 4
`define PIELAT_BIT_SESSION_END 3
`define PIELAT_BIT_SESSION_VALID 2
`define PIELAT_BIT_BUS_POWER_VALID 1
`define PIELAT_BIT_HOST_DISCONNECT 0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PIELAT_RST_RISE 5'h1f
`define PIELAT_RST_FALL 5'h1f
`define PIELAT_RST_LATCH 5'h00
`define PIELAT_RST_STATUS 5'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PIELAT_CLK_KHZ 20000
`define PIELAT_ID_SETTLE_MS 50
`define PIELAT_ID_CNT_W 20

`endif

// [sim/pielat_chk.sv]
// Port checker for the interrupt event latch.
// Assumes one clk domain; bound to every pielat_latch instance.
`timescale 1ns/10ps
`default_nettype none
`include "pielat_regs.svh"
module pielat_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic srcSessionEnd,
  input wire logic srcSessionValid,
  input wire logic srcBusPowerValid,
  input wire logic srcHostDisconnect,
  input wire logic hostMode,
  input wire logic idPullupControl,
  input wire logic lowPowerEnter,
  input wire logic serialModeEnter,
  input wire logic carkitModeEnter,
  input wire logic regRdStb,
  input wire pielat_pkg::pielat_addr_t regAddr,
  input wire pielat_pkg::pielat_byte_t regRdData,
  input wire logic regRdValid,
  input wire pielat_pkg::pielat_src_t eventLatch
);
  // Host mode counts as a source: it gates the disconnect bit
  wire logic [4:0] srcs = {srcSessionEnd, srcSessionValid, srcBusPowerValid,
    srcHostDisconnect, hostMode};
  wire logic rdLatch = regRdStb && regAddr == `PIELAT_OFS_LATCH;
  wire logic modeIn = lowPowerEnter || serialModeEnter || carkitModeEnter;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_valid_after_read: assert property (regRdStb |=> regRdValid)
    else $error("read valid missing");
  a_valid_idle: assert property (!regRdStb |=> !regRdValid)
    else $error("read valid without read");
  a_reserved_zero: assert property (regRdData[7:5] == 3'h0)
    else $error("reserved bits set");
  a_read_clears: assert property (rdLatch |=> eventLatch == 5'h00)
    else $error("latch not cleared by read");
  a_read_returns: assert property (rdLatch |=>
    (regRdData[4:0] & $past(eventLatch)) == $past(eventLatch))
    else $error("read lost latch bits");
  // Id source is frozen while its pull-up is off and through the settle window after it turns on
  a_mode_clears: assert property (modeIn && $stable(srcs) &&
    !$past(rst) && !idPullupControl |=> eventLatch == 5'h00)
    else $error("mode kept latch");
  a_latch_holds: assert property (!rdLatch && !modeIn |=>
    (eventLatch & $past(eventLatch)) == $past(eventLatch))
    else $error("latch bit dropped");
  a_no_spurious_set: assert property (|(eventLatch[3:0] &
    ~$past(eventLatch[3:0])) && !$past(rst, 2) && !$past(rst, 3)
    |-> $past(srcs) != $past(srcs, 2)) else $error("set without change");
  a_status_live: assert property (regRdStb && !$past(rst) &&
    regAddr == `PIELAT_OFS_STATUS && $stable(srcs)
    |=> regRdData[3:1] == $past(srcs[4:2])) else $error("status wrong");
  c_read_set: cover property (rdLatch && eventLatch != 5'h00);
  c_mode_set: cover property (modeIn && eventLatch != 5'h00);
  c_status: cover property (regRdStb && regAddr == `PIELAT_OFS_STATUS);
endmodule : pielat_chk
bind pielat_latch pielat_chk pielat_chk_i (.*);
`default_nettype wire

// [sim/pielat_link.sv]
// Link-side model issuing register reads and writes.
// Assumes tasks are called just after a rising clk edge.
`timescale 1ns/10ps
`default_nettype none
module pielat_link (
  input wire logic clk,
  output logic wrStb = 1'b0,
  output logic rdStb = 1'b0,
  output pielat_pkg::pielat_addr_t addr = 6'h00,
  output pielat_pkg::pielat_byte_t wrData = 8'h00,
  input wire pielat_pkg::pielat_byte_t rdData
);
  // Latch reads are optional; the tests decide when, if ever
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    wrStb <= 1'b1;
    addr <= a;
    wrData <= v;
    @(posedge clk);
    wrStb <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    rdStb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rdStb <= 1'b0;
    @(posedge clk);
    v = rdData;
  endtask : rd
endmodule : pielat_link
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the interrupt event latch.
// Assumes hdl/ on the include path; short id settle count.
`timescale 1ns/10ps
`default_nettype none
`include "pielat_regs.svh"
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] src = 5'h01;
  logic hostMode = 1'b1;
  logic idPullupControl = 1'b0;
  logic [2:0] modeEnter = 3'h0;
  logic wrStb, rdStb, rdValid;
  pielat_pkg::pielat_addr_t addr;
  pielat_pkg::pielat_byte_t wrData, rdData;
  pielat_pkg::pielat_src_t eventLatch;
  int miscompares = 0;
  int nChecks = 0;
  always #25 clk = ~clk;
  pielat_latch #(.ID_SETTLE_CYCLES(20'h14)) pielat_latch_i (.clk(clk),
    .rst(rst), .srcIdGround(src[4]), .srcSessionEnd(src[3]),
    .srcSessionValid(src[2]), .srcBusPowerValid(src[1]),
    .srcHostDisconnect(src[0]), .hostMode(hostMode),
    .idPullupControl(idPullupControl), .lowPowerEnter(modeEnter[0]),
    .serialModeEnter(modeEnter[1]), .carkitModeEnter(modeEnter[2]),
    .regWrStb(wrStb), .regRdStb(rdStb), .regAddr(addr),
    .regWrData(wrData), .regRdData(rdData), .regRdValid(rdValid),
    .eventLatch(eventLatch));
  pielat_link pielat_link_i (.clk(clk), .wrStb(wrStb), .rdStb(rdStb),
    .addr(addr), .wrData(wrData), .rdData(rdData));
  task automatic chk(input string what, input logic [7:0] e, logic [7:0] g);
    nChecks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] v;
    pielat_link_i.rd(a, v);
    chk($sformatf("reg %h", a), e, v);
    chk("regRdValid", 8'h01, {7'h00, rdValid});
  endtask : rchk
  task automatic lchk(input logic [7:0] e);
    chk("eventLatch", e, {3'h0, eventLatch});
  endtask : lchk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  // Watchdog at 2000 cycles: the tests take about 110 cycles
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rchk(`PIELAT_OFS_LATCH, 8'h01);
    rchk(`PIELAT_OFS_LATCH, 8'h00);
    rchk(`PIELAT_OFS_FALL, 8'h1f);
    $display("reset test done");
    src[3] <= 1'b1;
    repeat (2) @(posedge clk);
    lchk(8'h08);
    pielat_link_i.wr(`PIELAT_OFS_LATCH, 8'hff);
    rchk(`PIELAT_OFS_LATCH, 8'h08);
    pielat_link_i.wr(`PIELAT_OFS_FALL_CLR, 8'h08);
    src[3] <= 1'b0;
    repeat (2) @(posedge clk);
    lchk(8'h00);
    rchk(`PIELAT_OFS_FALL, 8'h17);
    src[3] <= 1'b1;
    rchk(`PIELAT_OFS_LATCH, 8'h08);
    lchk(8'h00);
    $display("event test done");
    pielat_link_i.wr(`PIELAT_OFS_FALL_SET, 8'h08);
    rchk(`PIELAT_OFS_FALL, 8'h1f);
    pielat_link_i.wr(`PIELAT_OFS_RISE_CLR, 8'h02);
    src[1] <= 1'b1;
    repeat (2) @(posedge clk);
    lchk(8'h00);
    rchk(`PIELAT_OFS_RISE, 8'h1d);
    src[1] <= 1'b0;
    repeat (2) @(posedge clk);
    rchk(`PIELAT_OFS_LATCH, 8'h02);
    pielat_link_i.wr(`PIELAT_OFS_RISE_SET, 8'h02);
    rchk(`PIELAT_OFS_RISE, 8'h1f);
    $display("enable test done");
    for (int m = 0; m < 3; m++) begin
      src[2] <= ~src[2];
      repeat (2) @(posedge clk);
      lchk(8'h04);
      modeEnter[m] <= 1'b1;
      @(posedge clk);
      modeEnter[m] <= 1'b0;
      @(posedge clk);
      lchk(8'h00);
    end
    $display("mode test done");
    hostMode <= 1'b0;
    src[4] <= 1'b1;
    repeat (10) @(posedge clk);
    rchk(`PIELAT_OFS_STATUS, 8'h0c);
    rchk(`PIELAT_OFS_LATCH, 8'h01);
    idPullupControl <= 1'b1;
    repeat (15) @(posedge clk);
    lchk(8'h00);
    repeat (12) @(posedge clk);
    lchk(8'h10);
    $display("status test done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
